// ===== adctc.sv
// converter trigger, channel decode and scan control with APB registers
`timescale 1ns/1ns
module adctc #(
    parameter bit EXT_VARIANT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_timer_a,
    input wire logic trig_timer_b,
    input wire logic ext_trigger_pin,
    output adctc_pkg::adctc_core_req_s core_req,
    input wire adctc_pkg::adctc_core_rsp_s core_rsp,
    output logic conv_end_irq,
    output logic irq
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] trig;
        logic scan_en;
        logic scan_size;
        logic clk_hi;
        logic clk_lo;
        logic end_flag;
        logic irq_en;
        logic start;
        logic [3:0] chan;
        logic [1:0] evt;
        logic [1:0] evt_en;
        logic irq;
        logic conv_end_irq;
        logic [15:0][9:0] data;
        adctc_pkg::adctc_state_e state;
        logic [3:0] cur;
        logic [3:0] first;
        logic [3:0] last;
        adctc_pkg::adctc_core_req_s req;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
    } adctc_regs_s;

    adctc_regs_s r;
    adctc_regs_s next_r;

    // ************************************************************
    // channel decode
    // ************************************************************
    logic [3:0] dec_first;
    logic [3:0] dec_last;
    logic dec_ok;
    logic wr_commit;
    logic pin_fall;

    always_comb begin
        dec_first = r.chan;
        dec_last = r.chan;
        dec_ok = 1'b1;
        if (!r.scan_en) begin
            dec_ok = (r.chan[3:2] != 2'b10);
        end else if (!r.scan_size) begin
            dec_first = {r.chan[3:2], 2'b00};
            dec_last = r.chan;
            dec_ok = (r.chan[3:2] != 2'b10);
        end else begin
            dec_first = 4'h0;
            dec_last = {1'b0, r.chan[2:0]};
            dec_ok = !r.chan[3];
        end
    end

    // access phase with pready already high is the completing edge
    assign wr_commit = psel && penable && r.pready && pwrite;
    // only the second and third stages are compared
    assign pin_fall = r.pin_s3 && !r.pin_s2;

    function automatic logic [9:0] max_states(input logic hi, input logic lo);
        logic [9:0] s;
        s = adctc_pkg::STATES_530;
        if (EXT_VARIANT) begin
            case ({hi, lo})
                2'b00: s = adctc_pkg::STATES_530;
                2'b01: s = adctc_pkg::STATES_266;
                2'b10: s = adctc_pkg::STATES_134;
                default: s = adctc_pkg::STATES_68;
            endcase
        end else begin
            case ({hi, lo})
                2'b00: s = adctc_pkg::STATES_530;
                2'b01: s = adctc_pkg::STATES_68;
                2'b10: s = adctc_pkg::STATES_266;
                default: s = adctc_pkg::STATES_134;
            endcase
        end
        return s;
    endfunction : max_states

    function automatic logic [7:0] status_val(input adctc_regs_s q);
        logic [7:0] v;
        v = 8'h00;
        v[adctc_pkg::POS_END_FLAG] = q.end_flag;
        v[adctc_pkg::POS_IRQ_EN] = q.irq_en;
        v[adctc_pkg::POS_START] = q.start;
        if (EXT_VARIANT) begin
            v[3:0] = q.chan;
        end else begin
            v[adctc_pkg::POS_B_SCAN] = q.scan_en;
            v[adctc_pkg::POS_B_CLK_LO] = q.clk_lo;
            v[2:0] = q.chan[2:0];
        end
        return v;
    endfunction : status_val

    function automatic logic [7:0] ctrl_val(input adctc_regs_s q);
        logic [7:0] v;
        v = 8'h00;
        if (!EXT_VARIANT) begin
            v = adctc_pkg::B_CTRL_RESERVED;
            v[adctc_pkg::POS_B_CHAN_B3] = q.chan[3];
        end else begin
            v[adctc_pkg::POS_SCAN_EN] = q.scan_en;
            v[adctc_pkg::POS_SCAN_SIZE] = q.scan_size;
            v[adctc_pkg::POS_CLK_LO] = q.clk_lo;
        end
        v[7:6] = q.trig;
        v[adctc_pkg::POS_CLK_HI] = q.clk_hi;
        return v;
    endfunction : ctrl_val

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [7:0] w;
        logic [1:0] ev;
        logic hw_trig;
        w = pwdata[7:0];
        ev = 2'b00;
        hw_trig = 1'b0;
        next_r = r;
        next_r.req.start = 1'b0;
        next_r.pin_s1 = ext_trigger_pin;
        next_r.pin_s2 = r.pin_s1;
        next_r.pin_s3 = r.pin_s2;
        next_r.req.max_states = max_states(r.clk_hi, r.clk_lo);

        // bus answer: one wait state, then pready for one cycle
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            next_r.prdata = 32'h0;
            if (paddr[1:0] != 2'b00) begin
                next_r.pslverr = 1'b1;
            end else if (paddr == adctc_pkg::OFF_STATUS) begin
                next_r.prdata[7:0] = status_val(r);
            end else if (paddr == adctc_pkg::OFF_CTRL) begin
                next_r.prdata[7:0] = ctrl_val(r);
            end else if (paddr == adctc_pkg::OFF_EVT_STATUS) begin
                next_r.prdata[1:0] = r.evt;
            end else if (paddr == adctc_pkg::OFF_EVT_CLEAR) begin
                next_r.prdata = 32'h0;
            end else if (paddr == adctc_pkg::OFF_EVT_ENABLE) begin
                next_r.prdata[1:0] = r.evt_en;
            end else if (paddr >= adctc_pkg::OFF_DATA_BASE &&
                         paddr <= adctc_pkg::OFF_DATA_LAST) begin
                next_r.prdata[9:0] = r.data[paddr[5:2]];
            end else begin
                next_r.pslverr = 1'b1;
            end
        end

        // hardware trigger, gated by the select code
        case (r.trig)
            adctc_pkg::TRIG_TIMER_A: hw_trig = trig_timer_a;
            adctc_pkg::TRIG_TIMER_B: hw_trig = trig_timer_b;
            adctc_pkg::TRIG_PIN: hw_trig = pin_fall;
            default: hw_trig = 1'b0;
        endcase
        if (hw_trig) begin
            next_r.start = 1'b1;
        end

        // conversion sequencing
        case (r.state)
            adctc_pkg::ST_WAIT: begin
                if (r.start && !dec_ok) begin
                    // a prohibited code never reaches the core
                    next_r.start = 1'b0;
                    ev[adctc_pkg::EVT_BAD_SETTING] = 1'b1;
                end else if (r.start) begin
                    next_r.first = dec_first;
                    next_r.last = dec_last;
                    next_r.cur = dec_first;
                    next_r.req.chan = dec_first;
                    next_r.req.start = 1'b1;
                    next_r.state = adctc_pkg::ST_CONV;
                end
            end
            adctc_pkg::ST_CONV: begin
                if (!r.start) begin
                    // abort: a late done from the core is dropped
                    next_r.state = adctc_pkg::ST_WAIT;
                end else if (core_rsp.done) begin
                    next_r.data[r.cur] = core_rsp.result;
                    if (r.cur == r.last) begin
                        ev[adctc_pkg::EVT_END] = 1'b1;
                        if (!r.scan_en) begin
                            next_r.start = 1'b0;
                            next_r.state = adctc_pkg::ST_WAIT;
                        end else begin
                            next_r.cur = r.first;
                            next_r.req.chan = r.first;
                            next_r.req.start = 1'b1;
                        end
                    end else begin
                        next_r.cur = r.cur + 4'h1;
                        next_r.req.chan = r.cur + 4'h1;
                        next_r.req.start = 1'b1;
                    end
                end
            end
            default: next_r.state = adctc_pkg::ST_WAIT;
        endcase

        // software writes at the completing edge
        if (wr_commit && paddr == adctc_pkg::OFF_STATUS) begin
            if (!w[adctc_pkg::POS_END_FLAG]) begin
                next_r.end_flag = 1'b0;
            end
            next_r.irq_en = w[adctc_pkg::POS_IRQ_EN];
            next_r.start = w[adctc_pkg::POS_START] || hw_trig;
            if (EXT_VARIANT) begin
                next_r.chan = w[3:0];
            end else begin
                next_r.chan[2:0] = w[2:0];
                next_r.scan_en = w[adctc_pkg::POS_B_SCAN];
                next_r.clk_lo = w[adctc_pkg::POS_B_CLK_LO];
            end
        end
        if (wr_commit && paddr == adctc_pkg::OFF_CTRL) begin
            next_r.trig = w[7:6];
            next_r.clk_hi = w[adctc_pkg::POS_CLK_HI];
            if (EXT_VARIANT) begin
                next_r.scan_en = w[adctc_pkg::POS_SCAN_EN];
                next_r.scan_size = w[adctc_pkg::POS_SCAN_SIZE];
                next_r.clk_lo = w[adctc_pkg::POS_CLK_LO];
            end else begin
                next_r.chan[3] = w[adctc_pkg::POS_B_CHAN_B3];
            end
        end
        if (wr_commit && paddr == adctc_pkg::OFF_EVT_ENABLE) begin
            next_r.evt_en = w[1:0];
        end
        if (wr_commit && paddr == adctc_pkg::OFF_EVT_CLEAR) begin
            next_r.evt = r.evt & ~w[1:0];
        end

        // hardware set wins over a clear in the same cycle
        if (ev[adctc_pkg::EVT_END]) begin
            next_r.end_flag = 1'b1;
        end
        next_r.evt = next_r.evt | ev;
        next_r.irq = |(next_r.evt & next_r.evt_en);
        next_r.conv_end_irq = next_r.end_flag && next_r.irq_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.clk_hi <= EXT_VARIANT ? 1'b0 : adctc_pkg::B_CLK_HI_RESET;
            r.chan <= EXT_VARIANT ? 4'h0 : {adctc_pkg::B_CHAN_B3_RESET, 3'h0};
            r.state <= adctc_pkg::ST_WAIT;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign core_req = r.req;
    assign conv_end_irq = r.conv_end_irq;
    assign irq = r.irq;

    // ************************************************************
    // checks
    // ************************************************************
    sequence last_done_s;
        r.state == adctc_pkg::ST_CONV && r.start && core_rsp.done &&
            r.cur == r.last;
    endsequence

    chk_single_end: assert property (@(posedge pclk) disable iff (!presetn)
        last_done_s and !r.scan_en |=> r.end_flag && !r.start
            && r.state == adctc_pkg::ST_WAIT)
        else $error("single conversion did not end cleanly");

    chk_scan_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        last_done_s and r.scan_en |=> r.end_flag && core_req.start
            && core_req.chan == $past(r.first))
        else $error("scan group did not restart at its first channel");

    chk_launch: assert property (@(posedge pclk) disable iff (!presetn)
        r.state == adctc_pkg::ST_WAIT && r.start && dec_ok
            |=> core_req.start && core_req.chan == $past(dec_first))
        else $error("start did not reach the core");

    chk_pin_start: assert property (@(posedge pclk) disable iff (!presetn)
        r.trig == adctc_pkg::TRIG_PIN && pin_fall |=> r.start)
        else $error("pin falling edge did not set start");

    chk_trig_off: assert property (@(posedge pclk) disable iff (!presetn)
        r.trig == adctc_pkg::TRIG_OFF && !r.start && !wr_commit |=> !r.start)
        else $error("start set while triggers disabled");

    chk_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
        r.end_flag && !(wr_commit && paddr == adctc_pkg::OFF_STATUS
            && !pwdata[7]) |=> r.end_flag)
        else $error("end flag lost without a zero write");

    chk_ctrl_res: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !r.pready && paddr == adctc_pkg::OFF_CTRL
            |=> prdata[5:4] == (EXT_VARIANT ? prdata[5:4] : 2'h3)
            && prdata[1:0] == (EXT_VARIANT ? 2'h0 : 2'h3) && pready)
        else $error("reserved control bits read wrong");

    chk_max_time: assert property (@(posedge pclk) disable iff (!presetn)
        EXT_VARIANT && r.clk_hi && r.clk_lo && $stable(r.clk_lo)
            && $stable(r.clk_hi) |=> core_req.max_states
            == adctc_pkg::STATES_68)
        else $error("conversion time code not applied");

    chk_abort: assert property (@(posedge pclk) disable iff (!presetn)
        r.state == adctc_pkg::ST_CONV && !r.start
            |=> r.state == adctc_pkg::ST_WAIT && !core_req.start)
        else $error("cleared start did not abort");

    chk_store: assert property (@(posedge pclk) disable iff (!presetn)
        r.state == adctc_pkg::ST_CONV && r.start && core_rsp.done
            |=> r.data[$past(r.cur)] == $past(core_rsp.result))
        else $error("result not stored for its channel");
endmodule : adctc

// ===== adctc_pkg.sv
// constants, types and register map of the converter trigger/channel control
package adctc_pkg;
    // ************************************************************
    // register byte offsets on the bus
    // ************************************************************
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h08;
    localparam logic [7:0] OFF_EVT_CLEAR = 8'h0C;
    localparam logic [7:0] OFF_EVT_ENABLE = 8'h10;
    localparam logic [7:0] OFF_DATA_BASE = 8'h40;
    localparam logic [7:0] OFF_DATA_LAST = 8'h7C;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_END_FLAG = 7;
    localparam int POS_IRQ_EN = 6;
    localparam int POS_START = 5;
    localparam int POS_B_SCAN = 4;
    localparam int POS_B_CLK_LO = 3;
    localparam int POS_TRIG = 6;
    localparam int POS_SCAN_EN = 5;
    localparam int POS_SCAN_SIZE = 4;
    localparam int POS_CLK_HI = 3;
    localparam int POS_CLK_LO = 2;
    localparam int POS_B_CHAN_B3 = 2;
    localparam int EVT_END = 0;
    localparam int EVT_BAD_SETTING = 1;
    // ************************************************************
    // reset values, fixed read values and trigger select codes
    // ************************************************************
    localparam logic [7:0] B_CTRL_RESERVED = 8'h33;
    localparam logic B_CLK_HI_RESET = 1'b1;
    localparam logic B_CHAN_B3_RESET = 1'b1;
    localparam logic [1:0] TRIG_OFF = 2'h0;
    localparam logic [1:0] TRIG_TIMER_A = 2'h1;
    localparam logic [1:0] TRIG_TIMER_B = 2'h2;
    localparam logic [1:0] TRIG_PIN = 2'h3;
    // ************************************************************
    // longest conversion time in states, by clock code
    // ************************************************************
    localparam logic [9:0] STATES_530 = 10'h212;
    localparam logic [9:0] STATES_266 = 10'h10A;
    localparam logic [9:0] STATES_134 = 10'h086;
    localparam logic [9:0] STATES_68 = 10'h044;

    typedef enum logic {ST_WAIT, ST_CONV} adctc_state_e;

    typedef struct packed {
        logic start;
        logic [3:0] chan;
        logic [9:0] max_states;
    } adctc_core_req_s;

    typedef struct packed {
        logic done;
        logic [9:0] result;
    } adctc_core_rsp_s;
endpackage : adctc_pkg

// ===== adctc_core_model.sv
// behavioural model of the analog conversion core behind the block
`timescale 1ns/1ns
module adctc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire adctc_pkg::adctc_core_req_s req,
    output adctc_pkg::adctc_core_rsp_s rsp
);
    logic busy;
    logic [5:0] cnt;
    logic [3:0] ch;
    // ************************************************************
    // one done per start, after a short or a long conversion
    // ************************************************************
    // result toggles while idle so a stale value never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 6'h00;
            ch <= 4'h0;
            rsp <= {1'b0, 10'h3FF};
        end else begin
            rsp.done <= 1'b0;
            rsp.result <= ~rsp.result;
            if (req.start) begin
                busy <= 1'b1;
                ch <= req.chan;
                cnt <= slow ? 6'h28 : 6'h02;
            end else if (busy && cnt != 6'h00) begin
                cnt <= cnt - 6'h01;
            end else if (busy) begin
                busy <= 1'b0;
                rsp.done <= 1'b1;
                // a slow result differs, so a wrongly stored late done shows
                rsp.result <= {slow ? 6'h20 : 6'h10, ch};
            end
        end
    end
endmodule : adctc_core_model

// ===== tb_top.sv
// self-checking testbench of the converter trigger and channel control
`timescale 1ns/1ns
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trig_timer_a = 1'b0;
    logic trig_timer_b = 1'b0;
    logic ext_trigger_pin = 1'b1;
    logic slow = 1'b0;
    adctc_pkg::adctc_core_req_s core_req;
    adctc_pkg::adctc_core_rsp_s core_rsp;
    logic conv_end_irq;
    logic irq;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [3:0] seen_q[$];
    logic [9:0] last_states;
    logic [31:0] rv;
    logic rerr;

    adctc u_adctc (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_timer_a(trig_timer_a),
        .trig_timer_b(trig_timer_b), .ext_trigger_pin(ext_trigger_pin),
        .core_req(core_req), .core_rsp(core_rsp),
        .conv_end_irq(conv_end_irq), .irq(irq));
    adctc_core_model u_adctc_core_model (.pclk(pclk), .presetn(presetn),
        .slow(slow), .req(core_req), .rsp(core_rsp));

    always #2 pclk = ~pclk;

    // ************************************************************
    // monitors, timeout and shared tasks
    // ************************************************************
    always @(posedge pclk) begin
        if (core_req.start === 1'b1) begin
            seen_q.push_back(core_req.chan);
            last_states = core_req.max_states;
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask : rd

    task wst(input logic [7:0] d);
        apb(1'b1, adctc_pkg::OFF_STATUS, {24'h0, d});
    endtask : wst

    task wct(input logic [7:0] d);
        apb(1'b1, adctc_pkg::OFF_CTRL, {24'h0, d});
    endtask : wct

    task poll(input logic [7:0] mask, input logic [7:0] val);
        int n;
        n = 0;
        do begin
            apb(1'b0, adctc_pkg::OFF_STATUS, 32'h0);
            n++;
        end while ((rv[7:0] & mask) !== val && n < 60);
    endtask : poll

    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task fire(input int s);
        @(posedge pclk);
        trig_timer_a <= (s == 0);
        trig_timer_b <= (s == 1);
        ext_trigger_pin <= (s != 2);
        @(posedge pclk);
        trig_timer_a <= 1'b0;
        trig_timer_b <= 1'b0;
        repeat (4) @(posedge pclk);
        ext_trigger_pin <= 1'b1;
        repeat (30) @(posedge pclk);
    endtask : fire

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_regs;
        rd(adctc_pkg::OFF_CTRL, 32'h0);
        wct(8'hFF);
        rd(adctc_pkg::OFF_CTRL, 32'hFC);
        wct(8'h00);
        apb(1'b0, 8'h14, 32'h0);
        chk({rerr, rv[30:0]}, 32'h80000000);
        apb(1'b0, 8'h06, 32'h0);
        chk(rerr, 1'b1);
        $display("test regs done");
    endtask : t_regs

    // clock codes and single/scan-size mixes in one pass
    task t_single;
        logic [15:0] chs;
        logic [39:0] sts;
        logic [3:0] ch;
        chs = 16'hFC70;
        sts = {10'h044, 10'h086, 10'h10A, 10'h212};
        for (int i = 0; i < 4; i++) begin
            ch = chs[4*i+:4];
            wct({2'b00, 1'b0, i[0], i[1:0], 2'b00});
            seen_q.delete();
            wst({4'h2, ch});
            poll(8'h20, 8'h00);
            chk(rv, {24'h0, 4'h8, ch});
            chk(seen_q.size(), 1);
            chk(seen_q[0], ch);
            chk(last_states, sts[10*i+:10]);
            rd(adctc_pkg::OFF_DATA_BASE + {2'b00, ch, 2'b00}, {6'h10, ch});
            wst({4'hC, ch});
            settle();
            chk(conv_end_irq, 1'b1);
            wst({4'h0, ch});
            settle();
            chk(conv_end_irq, 1'b0);
            rd(adctc_pkg::OFF_STATUS, {24'h0, 4'h0, ch});
        end
        $display("test single done");
    endtask : t_single

    task t_bad;
        logic [23:0] cases;
        cases = {8'h38, 8'h2A, 8'h09};
        apb(1'b1, adctc_pkg::OFF_EVT_CLEAR, 32'h3);
        apb(1'b1, adctc_pkg::OFF_EVT_ENABLE, 32'h2);
        for (int i = 0; i < 3; i++) begin
            wct({cases[8*i+4+:4], 4'h0});
            seen_q.delete();
            wst({4'h2, cases[8*i+:4]});
            settle();
            rd(adctc_pkg::OFF_EVT_STATUS, 32'h2);
            chk(irq, 1'b1);
            chk(seen_q.size(), 0);
            rd(adctc_pkg::OFF_STATUS, {28'h0, cases[8*i+:4]});
            apb(1'b1, adctc_pkg::OFF_EVT_CLEAR, 32'h2);
            settle();
            chk(irq, 1'b0);
        end
        apb(1'b1, adctc_pkg::OFF_EVT_ENABLE, 32'h0);
        wct(8'h00);
        wst(8'h29);
        settle();
        chk(irq, 1'b0);
        rd(adctc_pkg::OFF_EVT_STATUS, 32'h2);
        apb(1'b1, adctc_pkg::OFF_EVT_CLEAR, 32'h3);
        $display("test bad done");
    endtask : t_bad

    // each entry: control nibble, code, group size, first input
    task t_scan;
        logic [79:0] tbl;
        logic [15:0] e;
        int n;
        tbl = {16'h2E3C, 16'h3340, 16'h2120, 16'h3780, 16'h2414};
        for (int i = 0; i < 5; i++) begin
            e = tbl[16*i+:16];
            wct({e[15:12], 4'h0});
            seen_q.delete();
            wst({4'h2, e[11:8]});
            poll(8'h80, 8'h80);
            chk(rv[7], 1'b1);
            n = 0;
            while (seen_q.size() <= e[7:4] && n < 300) begin
                @(posedge pclk);
                n++;
            end
            wst({4'h0, e[11:8]});
            for (int k = 0; k < e[7:4]; k++) begin
                chk(seen_q[k], e[3:0] + k);
            end
            chk(seen_q[e[7:4]], e[3:0]);
            rd(adctc_pkg::OFF_DATA_BASE + {e[3:0] + e[7:4] - 4'h1, 2'b00},
                {6'h10, e[3:0] + e[7:4] - 4'h1});
        end
        wct(8'h00);
        $display("test scan done");
    endtask : t_scan

    task t_trig;
        wst(8'h02);
        for (int t = 0; t < 4; t++) begin
            wct({t[1:0], 6'h00});
            for (int s = 0; s < 3; s++) begin
                seen_q.delete();
                fire(s);
                chk(seen_q.size(), (t == s + 1) ? 1 : 0);
            end
        end
        wct(8'h00);
        $display("test trig done");
    endtask : t_trig

    task t_abort;
        logic [31:0] old;
        int n;
        @(posedge pclk);
        slow <= 1'b1;
        apb(1'b0, adctc_pkg::OFF_DATA_BASE + 8'h0C, 32'h0);
        old = rv;
        seen_q.delete();
        wst(8'h23);
        n = 0;
        while (seen_q.size() == 0 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        wst(8'h03);
        repeat (60) @(posedge pclk);
        rd(adctc_pkg::OFF_DATA_BASE + 8'h0C, old);
        rd(adctc_pkg::OFF_STATUS, 32'h03);
        slow <= 1'b0;
        $display("test abort done");
    endtask : t_abort

    task final_report;
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_single();
        t_bad();
        t_scan();
        t_trig();
        t_abort();
        final_report();
    end
endmodule : tb_top
